/* include/tsg_consts.svh */
`ifndef TSG_CONSTS_SVH
`define TSG_CONSTS_SVH

`define TSG_CLK_NS 10
`define TSG_MS_NS 1000000
`define TSG_UNIT_NS 10000
`define TSG_UNIT_CYC (`TSG_UNIT_NS / `TSG_CLK_NS)
`define TSG_FRAME_MS 10
`define TSG_FRAME_BITS 64
`define TSG_BLINK_MS 1000
`define TSG_FAIL_BLINK_MS 250
`define TSG_REMOVE_MS 3000
`define TSG_STAT_FAIL_BIT 8
`define TSG_STAT_RESET 16'h0000
`define TSG_RNG_250 2'h0
`define TSG_RNG_500 2'h1
`define TSG_RNG_2000 2'h2
`define TSG_K_250_DPS10 16'h09C4
`define TSG_K_250_LEGACY 16'h61A8
`define TSG_K_500 16'h1388
`define TSG_K_2000 16'h4E20

`endif

/* include/tsg_pkg.sv */
package tsg_pkg;

	typedef enum logic [4:0] {
		TSG_CAL_IDLE = 5'b00001,
		TSG_CAL_REMOVE = 5'b00010,
		TSG_CAL_RUN = 5'b00100,
		TSG_CAL_READY = 5'b01000,
		TSG_CAL_FAIL = 5'b10000
	} tsg_cal_t;

	typedef enum logic [2:0] {
		TSG_CMD_QUERY = 3'h0,
		TSG_CMD_REPEAT = 3'h1,
		TSG_CMD_ZERO = 3'h2,
		TSG_CMD_SAVE = 3'h3,
		TSG_CMD_ANGLE_SET = 3'h4,
		TSG_CMD_OTHER = 3'h5
	} tsg_cmd_t;

endpackage

/* include/tsg_hist_if.sv */
`timescale 1ns/1ps
interface tsg_hist_if #(parameter int AW = 4, parameter int DW = 8);
	logic wrEn;
	logic [AW-1:0] wrAddr;
	logic [DW-1:0] wrData;
	logic rdEn;
	logic [AW-1:0] rdAddr;
	logic [DW-1:0] rdData;
	modport ctrl(output wrEn, wrAddr, wrData, rdEn, rdAddr, input rdData);
	modport mem(input wrEn, wrAddr, wrData, rdEn, rdAddr, output rdData);
endinterface

/* rtl/tsg_hist_mem.sv */
`timescale 1ns/1ps
module tsg_hist_mem #(
	parameter int AW = 4, // address width
	parameter int DW = 8 // word width
) (
	input wire logic clk_sys, // system clock
	tsg_hist_if.mem hist // history port
);
	logic [DW-1:0] mem [2**AW];
	logic [DW-1:0] rdData_r;

	if (AW < 1) begin : g_chk
		$error("tsg_hist_mem: AW must be at least 1");
	end

	always_ff @(posedge clk_sys) begin
		if (hist.wrEn) begin
			mem[hist.wrAddr] <= hist.wrData;
		end
		if (hist.rdEn) begin
			rdData_r <= mem[hist.rdAddr];
		end
	end

	assign hist.rdData = rdData_r;
endmodule

/* rtl/tsg_readout.sv */
`timescale 1ns/1ps
`include "tsg_consts.svh"
// Overview of operation
// - Rate per axis, range 250, 500 or 2000 degrees per second.
// - Legacy scaling: span 25000 divider 100 at 250, divider 10 otherwise.
// - Current scaling reports degrees per second times ten at every range.
// - Rate integrates to an angle per axis, reported in tenths of a degree.
// - Gyro readings go out on USB, serial and CAN links.
// - Pulse train carries the Z rate alongside track data.
// - Pulse train carries left, right, tape detect and marker data.
// - Pulse train repeats continuously, new content every 10 ms.
// - Power LED lights while the sensor runs.
// - Track LED lit with track, blending red left, green right.
// - Marker LEDs light while left or right marker is seen.
// - Calibration checks sensors; failure gives message, LED flash, status bit 8.
// - Maintenance or runtime zero starts calibration; save makes it permanent.
// - Start-up setting enabled runs calibration at power-up without command.
// - Start-up calibration shows green for marker removal, then red.
// - Successful start-up calibration flashes green once per second.
// - Text commands accepted on serial and USB ports.
// - Lines starting with question mark are queries.
// - Every direct query is appended to the history queue; replayed queries are not.
// - Lone hash re-executes the most recent query.
// - Hash with number replays one history query every that many ms.
// - Range select 0, 1, 2 for 250, 500, 2000; default 0.
// - Angle of a chosen axis can be preset, value in tenths of degree.
module tsg_readout #(
	parameter int MS_CYC = `TSG_MS_NS / `TSG_CLK_NS, // clocks per ms
	parameter int HIST_DEPTH = 16, // history queue entries
	parameter int SAMPLE_HZ = 100 // gyro sample rate
) (
	input wire logic clk_sys, // system clock
	input wire logic rst, // async reset, high
	input wire logic gyroValid, // new raw sample pulse
	input wire logic signed [15:0] gyroX, // raw X rate
	input wire logic signed [15:0] gyroY, // raw Y rate
	input wire logic signed [15:0] gyroZ, // raw Z rate
	input wire logic [1:0] gyroRangeSelect, // range code
	input wire logic legacyScale, // pre-v3 scaling
	input wire logic signed [15:0] trackLeft, // left track mm
	input wire logic signed [15:0] trackRight, // right track mm
	input wire logic tapeDetect, // track present
	input wire logic markerLeft, // left marker seen
	input wire logic markerRight, // right marker seen
	input wire logic singleWirePulseTrainMode, // pulse train on
	input wire logic startupFieldCalSetting, // cal at power-up
	input wire logic cmdValid, // command line pulse
	input wire tsg_pkg::tsg_cmd_t cmdKind, // decoded kind
	input wire logic [7:0] cmdCode, // query code
	input wire logic signed [15:0] cmdArg, // period or angle
	input wire logic [1:0] cmdAxis, // axis 0..2
	input wire logic calDone, // field cal finished
	input wire logic calFail, // integrity test failed
	output logic calStart, // start field cal pulse
	output logic calCommit, // store cal pulse
	output logic errMsg, // failure message pulse
	output logic queryExec, // execute query pulse
	output logic [7:0] queryCode, // query to execute
	output logic signed [15:0] rateX, // X dps*10
	output logic signed [15:0] rateY, // Y dps*10
	output logic signed [15:0] rateZ, // Z dps*10
	output logic signed [15:0] angleX, // X deg*10
	output logic signed [15:0] angleY, // Y deg*10
	output logic signed [15:0] angleZ, // Z deg*10
	output logic [15:0] statusWord, // sensor status
	output logic pulseOut, // single wire output
	output logic ledPower, // power LED
	output logic ledTrackRed, // track LED red
	output logic ledTrackGreen, // track LED green
	output logic ledMarkerLeft, // left marker LED
	output logic ledMarkerRight // right marker LED
);
	localparam int AW = $clog2(HIST_DEPTH);
	localparam int MSW = $clog2(MS_CYC + 1);
	localparam int UW = $clog2(`TSG_UNIT_CYC + 1);

	if (MS_CYC < 1 || SAMPLE_HZ < 1 || HIST_DEPTH < 2 ||
			HIST_DEPTH != 2**AW) begin : g_chk
		$error("tsg_readout: unsupported parameter values");
	end

	typedef struct packed {
		logic powerOn;
		logic strapDone;
		logic [7:0] pwmCnt;
		logic [MSW-1:0] msCnt;
		logic msTick;
		logic [3:0] frameMs;
		logic [2:0][15:0] rate;
		logic [2:0][31:0] acc;
		logic [2:0][15:0] angle;
		logic [15:0] status;
		tsg_pkg::tsg_cal_t cal;
		logic calBoot;
		logic calPend;
		logic [11:0] calMs;
		logic calStartP;
		logic calCommitP;
		logic errP;
		logic [`TSG_FRAME_BITS-1:0] txSh;
		logic [6:0] txLeft;
		logic [1:0] txPh;
		logic [UW-1:0] txUnit;
		logic pulse;
		logic ledG;
		logic ledR;
		logic ledML;
		logic ledMR;
		logic [AW-1:0] wrPtr;
		logic [AW:0] histCnt;
		logic [AW-1:0] rptIdx;
		logic rptOn;
		logic [15:0] rptPer;
		logic [15:0] rptMs;
		logic rdWait;
		logic holdV;
		logic [7:0] holdCode;
		logic qExec;
		logic [7:0] qCode;
	} tsg_state_t;

	tsg_state_t state_r;
	tsg_state_t state_nxt;
	logic wrEn;
	logic rdEn;
	logic [AW-1:0] rdAddr;

	tsg_hist_if #(.AW(AW), .DW(8)) hist ();

	tsg_hist_mem #(.AW(AW), .DW(8)) u_hist (
		.clk_sys(clk_sys),
		.hist(hist)
	);

	// Constant multiply then >>15 keeps full-scale raw at the span edge
	function automatic logic [15:0] scaleRate(
		input logic signed [15:0] raw,
		input logic [1:0] rng,
		input logic legacy
	);
		logic signed [31:0] prod;
		logic [15:0] k;
		k = legacy ? `TSG_K_250_LEGACY : `TSG_K_250_DPS10;
		if (rng == `TSG_RNG_500) begin
			k = `TSG_K_500;
		end else if (rng == `TSG_RNG_2000) begin
			k = `TSG_K_2000;
		end
		prod = 32'(raw) * $signed({16'h0000, k});
		return prod[30:15];
	endfunction

	function automatic logic [15:0] angleOf(input logic [31:0] acc);
		return 16'($signed(acc) / SAMPLE_HZ);
	endfunction

	always_comb begin
		logic signed [15:0] raw [3];
		logic signed [16:0] pos;
		logic [7:0] gDuty;
		logic zeroCmd;
		logic frameGo;
		logic dirQuery;
		logic [AW-1:0] oldest;
		raw[0] = gyroX;
		raw[1] = gyroY;
		raw[2] = gyroZ;
		pos = 17'(($signed({trackLeft[15], trackLeft}) +
			$signed({trackRight[15], trackRight})) >>> 1);
		gDuty = 8'h80;
		zeroCmd = cmdValid && cmdKind == tsg_pkg::TSG_CMD_ZERO;
		dirQuery = cmdValid && cmdKind == tsg_pkg::TSG_CMD_QUERY;
		oldest = state_r.wrPtr - state_r.histCnt[AW-1:0];
		frameGo = 1'b0;
		wrEn = 1'b0;
		rdEn = 1'b0;
		rdAddr = '0;
		state_nxt = state_r;
		state_nxt.msTick = 1'b0;
		state_nxt.calStartP = 1'b0;
		state_nxt.calCommitP = 1'b0;
		state_nxt.errP = 1'b0;
		state_nxt.qExec = 1'b0;
		state_nxt.powerOn = 1'b1;
		state_nxt.pwmCnt = state_r.pwmCnt + 8'h01;
		if (state_r.msCnt == MSW'(MS_CYC - 1)) begin
			state_nxt.msCnt = '0;
			state_nxt.msTick = 1'b1;
		end else begin
			state_nxt.msCnt = state_r.msCnt + 1'b1;
		end

		// Gyro scaling, integration and preset
		for (int i = 0; i < 3; i++) begin
			if (gyroValid) begin
				state_nxt.rate[i] = scaleRate(raw[i], gyroRangeSelect,
					legacyScale);
				state_nxt.acc[i] = state_r.acc[i] +
					{{16{state_nxt.rate[i][15]}}, state_nxt.rate[i]};
			end
			if (cmdValid && cmdKind == tsg_pkg::TSG_CMD_ANGLE_SET &&
					cmdAxis == 2'(i)) begin
				state_nxt.acc[i] = 32'($signed(cmdArg) * SAMPLE_HZ);
			end
			state_nxt.angle[i] = angleOf(state_r.acc[i]);
		end

		// Default LED view: blend follows mean of both tracks
		if (pos > 17'sh0007F) begin
			gDuty = 8'hFF;
		end else if (pos < -17'sh0007F) begin
			gDuty = 8'h01;
		end else begin
			gDuty = 8'(pos[7:0] + 8'h80);
		end
		state_nxt.ledG = tapeDetect && state_r.pwmCnt < gDuty;
		state_nxt.ledR = tapeDetect && state_r.pwmCnt >= gDuty;
		state_nxt.ledML = markerLeft;
		state_nxt.ledMR = markerRight;

		// Calibration; save goes first so a same-cycle pass stays pending
		if (cmdValid && cmdKind == tsg_pkg::TSG_CMD_SAVE &&
				state_r.calPend) begin
			state_nxt.calCommitP = 1'b1;
			state_nxt.calPend = 1'b0;
		end
		unique case (state_r.cal)
			tsg_pkg::TSG_CAL_IDLE: begin
				if (!state_r.strapDone) begin
					state_nxt.strapDone = 1'b1;
					if (startupFieldCalSetting) begin
						state_nxt.cal = tsg_pkg::TSG_CAL_REMOVE;
						state_nxt.calBoot = 1'b1;
						state_nxt.calMs = '0;
					end
				end else if (zeroCmd) begin
					state_nxt.cal = tsg_pkg::TSG_CAL_RUN;
					state_nxt.calBoot = 1'b0;
					state_nxt.calStartP = 1'b1;
				end
			end
			tsg_pkg::TSG_CAL_REMOVE: begin
				state_nxt.ledG = 1'b1;
				state_nxt.ledR = 1'b0;
				if (state_r.msTick) begin
					state_nxt.calMs = state_r.calMs + 12'h001;
					if (state_r.calMs == 12'(`TSG_REMOVE_MS - 1)) begin
						state_nxt.cal = tsg_pkg::TSG_CAL_RUN;
						state_nxt.calStartP = 1'b1;
					end
				end
			end
			tsg_pkg::TSG_CAL_RUN: begin
				state_nxt.ledG = 1'b0;
				state_nxt.ledR = 1'b1;
				state_nxt.calMs = '0;
				if (calDone && calFail) begin
					state_nxt.cal = tsg_pkg::TSG_CAL_FAIL;
					state_nxt.status[`TSG_STAT_FAIL_BIT] = 1'b1;
					state_nxt.errP = 1'b1;
				end else if (calDone) begin
					state_nxt.status[`TSG_STAT_FAIL_BIT] = 1'b0;
					state_nxt.cal = state_r.calBoot ?
						tsg_pkg::TSG_CAL_READY : tsg_pkg::TSG_CAL_IDLE;
					state_nxt.calPend = !state_r.calBoot;
				end
			end
			tsg_pkg::TSG_CAL_READY: begin
				state_nxt.ledG =
					state_r.calMs < 12'(`TSG_BLINK_MS / 2);
				state_nxt.ledR = 1'b0;
				if (state_r.msTick) begin
					state_nxt.calMs =
						(state_r.calMs == 12'(`TSG_BLINK_MS - 1)) ?
						12'h000 : state_r.calMs + 12'h001;
				end
				if (zeroCmd) begin
					state_nxt.cal = tsg_pkg::TSG_CAL_RUN;
					state_nxt.calBoot = 1'b0;
					state_nxt.calStartP = 1'b1;
				end else if (tapeDetect) begin
					state_nxt.cal = tsg_pkg::TSG_CAL_IDLE;
				end
			end
			tsg_pkg::TSG_CAL_FAIL: begin
				// Track and marker LEDs flash until a new calibration is asked for
				state_nxt.ledG =
					state_r.calMs < 12'(`TSG_FAIL_BLINK_MS / 2);
				state_nxt.ledR = state_nxt.ledG;
				state_nxt.ledML = state_nxt.ledG;
				state_nxt.ledMR = state_nxt.ledG;
				if (state_r.msTick) begin
					state_nxt.calMs =
						(state_r.calMs == 12'(`TSG_FAIL_BLINK_MS - 1)) ?
						12'h000 : state_r.calMs + 12'h001;
				end
				if (zeroCmd) begin
					state_nxt.cal = tsg_pkg::TSG_CAL_RUN;
					state_nxt.calBoot = 1'b0;
					state_nxt.calStartP = 1'b1;
				end
			end
			default: begin
				state_nxt.cal = tsg_pkg::TSG_CAL_IDLE;
			end
		endcase

		// Pulse train: 3-unit cells, high 1 unit for 0, 2 units for 1
		if (state_r.msTick) begin
			frameGo = state_r.frameMs == 4'(`TSG_FRAME_MS - 1);
			state_nxt.frameMs = frameGo ? 4'h0 : state_r.frameMs + 4'h1;
		end
		if (!singleWirePulseTrainMode) begin
			state_nxt.txLeft = '0;
		end else if (state_r.txLeft == 7'h00) begin
			if (frameGo) begin
				state_nxt.txSh = {trackLeft, trackRight, 13'h0000,
					markerRight, markerLeft, tapeDetect,
					state_r.rate[2]};
				state_nxt.txLeft = 7'(`TSG_FRAME_BITS);
				state_nxt.txPh = 2'h0;
				state_nxt.txUnit = '0;
			end
		end else if (state_r.txUnit == UW'(`TSG_UNIT_CYC - 1)) begin
			state_nxt.txUnit = '0;
			if (state_r.txPh == 2'h2) begin
				state_nxt.txPh = 2'h0;
				state_nxt.txSh = {state_r.txSh[`TSG_FRAME_BITS-2:0], 1'b0};
				state_nxt.txLeft = state_r.txLeft - 7'h01;
			end else begin
				state_nxt.txPh = state_r.txPh + 2'h1;
			end
		end else begin
			state_nxt.txUnit = state_r.txUnit + 1'b1;
		end
		state_nxt.pulse = singleWirePulseTrainMode &&
			state_r.txLeft != 7'h00 && (state_r.txPh == 2'h0 ||
			(state_r.txPh == 2'h1 && state_r.txSh[`TSG_FRAME_BITS-1]));

		// Query history and repetition
		if (dirQuery) begin
			wrEn = 1'b1;
			state_nxt.wrPtr = state_r.wrPtr + 1'b1;
			if (state_r.histCnt != (AW + 1)'(HIST_DEPTH)) begin
				state_nxt.histCnt = state_r.histCnt + 1'b1;
			end
		end
		if (cmdValid && cmdKind != tsg_pkg::TSG_CMD_REPEAT) begin
			state_nxt.rptOn = 1'b0;
		end else if (cmdValid && cmdArg == 16'sh0000) begin
			rdEn = state_r.histCnt != '0;
			rdAddr = state_r.wrPtr - 1'b1;
		end else if (cmdValid) begin
			state_nxt.rptOn = cmdArg > 16'sh0000;
			state_nxt.rptPer = cmdArg;
			state_nxt.rptMs = '0;
			state_nxt.rptIdx = '0;
		end else if (state_r.rptOn && state_r.msTick) begin
			state_nxt.rptMs = state_r.rptMs + 16'h0001;
			if (state_r.rptMs == state_r.rptPer - 16'h0001) begin
				state_nxt.rptMs = '0;
				rdEn = state_r.histCnt != '0;
				rdAddr = oldest + state_r.rptIdx;
				state_nxt.rptIdx =
					((AW + 1)'(state_r.rptIdx) + 1'b1 >= state_r.histCnt) ?
					'0 : state_r.rptIdx + 1'b1;
			end
		end
		state_nxt.rdWait = rdEn;
		if (state_r.rdWait) begin
			state_nxt.holdV = 1'b1;
			state_nxt.holdCode = hist.rdData;
		end
		// A direct query wins the cycle; a replay waits one more
		if (dirQuery) begin
			state_nxt.qExec = 1'b1;
			state_nxt.qCode = cmdCode;
		end else if (state_r.holdV) begin
			state_nxt.qExec = 1'b1;
			state_nxt.qCode = state_r.holdCode;
			state_nxt.holdV = state_r.rdWait;
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			state_r <= '0;
			state_r.cal <= tsg_pkg::TSG_CAL_IDLE;
			state_r.status <= `TSG_STAT_RESET;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign hist.wrEn = wrEn;
	assign hist.wrAddr = state_r.wrPtr;
	assign hist.wrData = cmdCode;
	assign hist.rdEn = rdEn;
	assign hist.rdAddr = rdAddr;

	// Readings are held here for whichever link front end asks
	assign rateX = state_r.rate[0];
	assign rateY = state_r.rate[1];
	assign rateZ = state_r.rate[2];
	assign angleX = state_r.angle[0];
	assign angleY = state_r.angle[1];
	assign angleZ = state_r.angle[2];
	assign statusWord = state_r.status;
	assign calStart = state_r.calStartP;
	assign calCommit = state_r.calCommitP;
	assign errMsg = state_r.errP;
	assign queryExec = state_r.qExec;
	assign queryCode = state_r.qCode;
	assign pulseOut = state_r.pulse;
	assign ledPower = state_r.powerOn;
	assign ledTrackRed = state_r.ledR;
	assign ledTrackGreen = state_r.ledG;
	assign ledMarkerLeft = state_r.ledML;
	assign ledMarkerRight = state_r.ledMR;
endmodule

/* dv/tsg_readout_monitor.sv */
`timescale 1ns/1ps
module tsg_readout_monitor (
	input wire logic clk_sys, // system clock
	input wire logic rst, // async reset, high
	input wire logic gyroValid, // sample strobe
	input wire logic signed [15:0] gyroZ, // raw Z rate
	input wire logic [1:0] gyroRangeSelect, // range code
	input wire logic legacyScale, // old scaling
	input wire logic markerLeft, // left marker
	input wire logic singleWirePulseTrainMode, // pulse mode
	input wire logic cmdValid, // command strobe
	input wire tsg_pkg::tsg_cmd_t cmdKind, // command kind
	input wire logic [7:0] cmdCode, // query code
	input wire logic calDone, // cal finished
	input wire logic calFail, // cal failed
	input wire logic calCommit, // store pulse
	input wire logic errMsg, // failure message
	input wire logic queryExec, // query pulse
	input wire logic [7:0] queryCode, // executed query
	input wire logic signed [15:0] rateZ, // scaled Z rate
	input wire logic [15:0] statusWord, // status
	input wire logic pulseOut, // single wire
	input wire logic ledPower, // power LED
	input wire logic ledMarkerLeft // left marker LED
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	function automatic logic signed [15:0] expRate(logic signed [15:0] r,
			logic [1:0] g, logic l);
		int k;
		k = g == 2'h1 ? 5000 : g == 2'h2 ? 20000 : l ? 25000 : 2500;
		return 16'((int'(r) * k) >>> 15);
	endfunction

	power_on_a: assert property (!$past(rst) |-> ledPower)
		else $error("power LED dark while running");
	query_exec_a: assert property (
		cmdValid && cmdKind == tsg_pkg::TSG_CMD_QUERY
		|=> queryExec && queryCode == $past(cmdCode))
		else $error("query not executed next cycle");
	rate_scale_a: assert property (
		gyroValid ##1 !gyroValid ##1 !gyroValid |=> rateZ == expRate(
		$past(gyroZ, 3), $past(gyroRangeSelect, 3), $past(legacyScale, 3)))
		else $error("Z rate scaled wrongly");
	err_cause_a: assert property ($rose(errMsg) |->
		($past(calDone) && $past(calFail)) ||
		($past(calDone, 2) && $past(calFail, 2)))
		else $error("failure message without failed calibration");
	fail_msg_a: assert property (calDone && calFail |-> ##[1:2] errMsg)
		else $error("failed calibration gave no message");
	fail_bit_a: assert property (calDone && calFail |-> ##2 statusWord[8])
		else $error("failure bit not set");
	pass_clear_a: assert property (
		calDone && !calFail |-> ##2 !statusWord[8])
		else $error("failure bit not cleared by passing calibration");
	commit_cause_a: assert property (calCommit |->
		$past(cmdValid) && $past(cmdKind) == tsg_pkg::TSG_CMD_SAVE)
		else $error("store pulse without save command");
	marker_led_a: assert property (
		!statusWord[8] && !$past(statusWord[8]) && !$past(rst)
		|-> ledMarkerLeft == $past(markerLeft))
		else $error("left marker LED does not follow marker");
	pulse_idle_a: assert property (
		!$past(singleWirePulseTrainMode) &&
		!$past(singleWirePulseTrainMode, 2) |-> !pulseOut)
		else $error("pulse output active with mode off");
endmodule

bind tsg_readout tsg_readout_monitor MON (.*);

/* dv/tsg_pulse_rx.sv */
`timescale 1ns/1ps
module tsg_pulse_rx (
	input wire logic clk_sys, // system clock
	input wire logic pulseIn, // single wire from sensor
	output logic [63:0] frameBits, // cells so far, newest in LSB
	output int cellCount // cells decoded
);
	int highCyc = 0;
	logic prev = 1'b0;
	initial begin
		frameBits = '0;
		cellCount = 0;
	end
	// Input set up for this sensor's cell format
	always @(posedge clk_sys) begin
		prev <= pulseIn;
		if (pulseIn) begin
			highCyc <= highCyc + 1;
		end else if (prev) begin
			// Two high units mean a one; threshold sits between 1 and 2
			frameBits <= {frameBits[62:0], highCyc > 1500};
			cellCount <= cellCount + 1;
			highCyc <= 0;
		end
	end
endmodule

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
	logic clk_sys, rst, gyroValid, legacyScale, tapeDetect, markerLeft;
	logic markerRight, singleWirePulseTrainMode, startupFieldCalSetting;
	logic cmdValid, calDone, calFail, calStart, calCommit, errMsg, queryExec;
	logic pulseOut, ledPower, ledTrackRed, ledTrackGreen, ledMarkerLeft;
	logic ledMarkerRight;
	logic signed [15:0] gyroZ, trackLeft, trackRight, cmdArg, rateX, rateY;
	logic signed [15:0] rateZ, angleX, angleY, angleZ;
	logic [15:0] statusWord;
	logic [7:0] cmdCode, queryCode;
	logic [1:0] gyroRangeSelect, cmdAxis;
	tsg_pkg::tsg_cmd_t cmdKind;
	logic [63:0] rxBits;
	int rxCount, miscompares = 0, checks_done = 0;

	// Short ms so every ms timing fits the run
	tsg_readout #(.MS_CYC(10)) DUT (.*, .gyroX(gyroZ), .gyroY(gyroZ));
	tsg_pulse_rx RX (.clk_sys, .pulseIn(pulseOut), .frameBits(rxBits),
		.cellCount(rxCount));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic pick(int sel);
		case (sel)
			0: return queryExec;
			1: return calStart;
			2: return calCommit;
			3: return errMsg;
			4: return rxCount >= 4;
			5: return ledTrackGreen;
			6: return ledTrackRed | ledTrackGreen;
			default: return ledMarkerRight;
		endcase
	endfunction

	task automatic waitHi(int sel, int lim);
		int n;
		n = 0;
		while (pick(sel) !== 1'b1) begin
			if (n == lim) begin
				miscompares++;
				$display("unexpected wait %0d expected 1 seen 0", sel);
				tally_and_finish();
			end
			n++;
			@(negedge clk_sys);
		end
	endtask

	task automatic cnt(int sel, int cyc, output int n);
		n = 0;
		repeat (cyc) begin
			@(negedge clk_sys);
			n += int'(pick(sel) === 1'b1);
		end
	endtask

	task automatic cmd(tsg_pkg::tsg_cmd_t k, logic [7:0] c, int a);
		cmdKind = k;
		cmdCode = c;
		cmdArg = 16'(a);
		cmdValid = 1'b1;
		@(negedge clk_sys);
		cmdValid = 1'b0;
	endtask

	task automatic gs();
		gyroValid = 1'b1;
		@(negedge clk_sys);
		gyroValid = 1'b0;
		repeat (3) @(negedge clk_sys);
	endtask

	task automatic cd(logic f);
		calFail = f;
		calDone = 1'b1;
		@(negedge clk_sys);
		calDone = 1'b0;
	endtask

	task automatic rstSeq(logic s);
		rst = 1'b1;
		startupFieldCalSetting = s;
		repeat (12) @(negedge clk_sys);
		rst = 1'b0;
		@(negedge clk_sys);
	endtask

	task automatic t_gyro();
		int k;
		for (int g = 0; g < 3; g++) begin
			for (int l = 0; l < 2; l++) begin
				k = g == 1 ? 5000 : g == 2 ? 20000 : l ? 25000 : 2500;
				gyroRangeSelect = 2'(g);
				legacyScale = l[0];
				gyroZ = l ? 16'hC000 : 16'h4000;
				gs();
				chk("rateZ", rateZ, l ? -k / 2 : k / 2);
				chk("rateX", rateX, l ? -k / 2 : k / 2);
			end
		end
		gyroRangeSelect = 2'h0;
		legacyScale = 1'b0;
		cmdAxis = 2'h2;
		cmd(tsg_pkg::TSG_CMD_ANGLE_SET, 8'h00, 900);
		repeat (3) @(negedge clk_sys);
		chk("angleZ preset", angleZ, 900);
		gyroZ = 16'h4000;
		gs();
		chk("angleZ", angleZ, 912);
		// X and Y saw every sample: net rate -10000 at 100 Hz
		chk("angleX", angleX, -100);
		chk("angleY", angleY, -100);
	endtask

	task automatic t_leds();
		int n;
		chk("ledPower", ledPower, 1);
		markerLeft = 1'b1;
		markerRight = 1'b1;
		repeat (2) @(negedge clk_sys);
		chk("ledMarkerLeft", ledMarkerLeft, 1);
		chk("ledMarkerRight", ledMarkerRight, 1);
		markerLeft = 1'b0;
		markerRight = 1'b0;
		tapeDetect = 1'b1;
		trackLeft = 16'hFF38;
		trackRight = 16'hFF38;
		repeat (2) @(negedge clk_sys);
		cnt(5, 256, n);
		// Blend clamps at one step of 256, never fully dark
		chk("green at left", n, 1);
		trackLeft = 16'h00C8;
		trackRight = 16'h00C8;
		repeat (2) @(negedge clk_sys);
		cnt(5, 256, n);
		chk("green at right", n, 255);
		tapeDetect = 1'b0;
		repeat (2) @(negedge clk_sys);
		cnt(6, 256, n);
		chk("track LED without tape", n, 0);
		chk("ledMarkerRight", ledMarkerRight, 0);
	endtask

	task automatic t_query();
		int n;
		cmd(tsg_pkg::TSG_CMD_QUERY, 8'h21, 0);
		waitHi(0, 3);
		@(negedge clk_sys);
		cmd(tsg_pkg::TSG_CMD_QUERY, 8'h22, 0);
		waitHi(0, 3);
		chk("queryCode", queryCode, 8'h22);
		@(negedge clk_sys);
		cmd(tsg_pkg::TSG_CMD_REPEAT, 8'h00, 0);
		waitHi(0, 5);
		chk("lone repeat", queryCode, 8'h22);
		@(negedge clk_sys);
		cmd(tsg_pkg::TSG_CMD_REPEAT, 8'h00, 2);
		for (int i = 0; i < 3; i++) begin
			waitHi(0, 40);
			chk("periodic", queryCode, i == 1 ? 8'h22 : 8'h21);
			@(negedge clk_sys);
		end
		cmd(tsg_pkg::TSG_CMD_OTHER, 8'h00, 0);
		cnt(0, 60, n);
		chk("replays after stop", n, 0);
	endtask

	task automatic t_cal();
		int n;
		cmd(tsg_pkg::TSG_CMD_ZERO, 8'h00, 0);
		waitHi(1, 3);
		cd(1'b1);
		waitHi(3, 3);
		repeat (2) @(negedge clk_sys);
		chk("failure bit", statusWord[8], 1);
		cnt(7, 3000, n);
		chk("flashing", n != 0, 1);
		cmd(tsg_pkg::TSG_CMD_ZERO, 8'h00, 0);
		waitHi(1, 3);
		cd(1'b0);
		repeat (3) @(negedge clk_sys);
		chk("failure bit", statusWord[8], 0);
		cmd(tsg_pkg::TSG_CMD_SAVE, 8'h00, 0);
		waitHi(2, 3);
		@(negedge clk_sys);
		cmd(tsg_pkg::TSG_CMD_SAVE, 8'h00, 0);
		cnt(2, 4, n);
		chk("second store", n, 0);
	endtask

	task automatic t_pulse();
		trackLeft = 16'hA5C3;
		singleWirePulseTrainMode = 1'b1;
		waitHi(4, 20000);
		chk("frame head", rxBits[3:0], 4'hA);
		singleWirePulseTrainMode = 1'b0;
		repeat (4) @(negedge clk_sys);
		chk("pulseOut idle", pulseOut, 0);
	endtask

	task automatic t_startup();
		int n;
		repeat (5) @(negedge clk_sys);
		chk("remove green", {ledTrackRed, ledTrackGreen}, 2'b01);
		waitHi(1, 31000);
		repeat (3) @(negedge clk_sys);
		chk("calibrating red", ledTrackRed, 1);
		cd(1'b0);
		cnt(5, 11000, n);
		chk("ready blink", n >= 5000 && n <= 6000, 1);
	endtask

	initial begin
		{gyroValid, legacyScale, tapeDetect, markerLeft, markerRight} = '0;
		{singleWirePulseTrainMode, cmdValid, calDone, calFail} = '0;
		{gyroZ, trackLeft, trackRight, cmdArg} = '0;
		{cmdCode, gyroRangeSelect, cmdAxis} = '0;
		cmdKind = tsg_pkg::TSG_CMD_OTHER;
		rstSeq(1'b0);
		t_gyro();
		t_leds();
		t_query();
		t_cal();
		t_pulse();
		rstSeq(1'b1);
		t_startup();
		tally_and_finish();
	end
endmodule
